//--- verilog/buck_mode_pg_ctrl.sv
/*
  Supply-good indication, default targets, low-power gating and
  phase timing for two step-down converters, with an Avalon-MM slave.
  Assumes comparator flags arrive asynchronously from the analog
  stage; strap and enable pins are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "buck_pg_defines.svh"
// Overview of operation
// RL1: supply good when a charger input valid
// RL2: supply good off in charger sleep
// RL3: sleep when neither input is present
// RL4: overvoltage adapter never counts as valid
// RL5: charger reset holds supply good high-Z
// RL6: indicator registers override charger supply good
// RL7: suspend charging while junction flag hot
// RL8: main default from main strap
// RL9: core default from core strap
// RL10: software may rewrite both targets
// RL11: sleep request lowers or disables core
// RL12: sleep request ignored unless enabled
// RL13: bit seven forces fixed PWM
// RL14: PWM at fixed 1.25 MHz
// RL15: core starts 270 degrees after main
// RL16: switch on at start, off on trip
// RL17: low current enters power-save mode
// RL18: half-rate bursts between low and high
// RL19: nominal threshold in burst returns PWM
// RL20: dropout keeps high side on
// RL21: soft start in four current steps
// RL22: discharge on fault only if enabled
// RL23: power-good of enabled converters readable
// RL24: comparator flags pass two-stage synchroniser
// RL25: blink counter compares on-time and period
module buck_mode_pg_ctrl #(
  parameter int BLINK_UNIT_CYC = `BLINK_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Asynchronous comparator flags
  input wire buck_pkg::chg_flags_t charger_flags_i,
  input wire buck_pkg::buck_flags_t main_flags_i,
  input wire buck_pkg::buck_flags_t core_flags_i,
  // Pins and sequencer controls
  input wire logic main_default_strap_i,
  input wire logic core_default_strap_i,
  input wire logic deep_sleep_request_i,
  input wire logic main_enable_i,
  input wire logic core_enable_i,
  input wire logic uvlo_i,
  input wire logic battery_lid_open_i,
  input wire logic overtemp_i,
  // Supply-good open-drain pin
  output logic supply_good_n_o,
  output logic supply_good_oe_o,
  // Converter controls
  output logic [3:0] main_target_o,
  output logic [3:0] core_target_o,
  output logic core_enable_o,
  output logic main_discharge_o,
  output logic core_discharge_o,
  output logic charge_suspend_o,
  output var buck_pkg::buck_drive_t main_drive_o,
  output var buck_pkg::buck_drive_t core_drive_o
);
  import buck_pkg::*;

  // ****************************************
  // Constants and checks
  // ****************************************
  localparam int PWM_CYC = `PWM_CYC; // Cycles per switching period
  localparam int CORE_SHIFT = `CORE_SHIFT_CYC; // Core start offset
  localparam int SYNC_W = $bits(chg_flags_t) + 2 * $bits(buck_flags_t);

  if (PWM_CYC < 4 || PWM_CYC > 16 || BLINK_UNIT_CYC < 1 || BLINK_UNIT_CYC > 1000000)
  begin : g_bad
    $error("buck_mode_pg_ctrl: timing parameter out of range");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic ack; // Bus answer phase
  logic [7:0] chg_cfg_r; // Charger configuration
  logic [7:0] on_time_r; // Indicator on-time
  logic [7:0] period_r; // Indicator period
  logic [7:0] ctrl_a_r; // Converter control A
  logic [7:0] ctrl_b_r; // Converter control B
  logic [3:0] main_vsel_r; // Main target code
  logic [3:0] core_vsel_r; // Core target code
  logic strap_taken_r; // Straps captured once
  logic [SYNC_W-1:0] meta_r; // First sync stage only
  logic [SYNC_W-1:0] sync_r; // Synchronised flags
  chg_flags_t chg_s; // Charger flags, synced
  buck_flags_t main_s; // Main flags, synced
  buck_flags_t core_s; // Core flags, synced
  logic [19:0] unit_cnt_r; // Blink time base
  logic [7:0] blink_cnt_r; // Blink position
  logic [3:0] phase_r; // Switching phase
  logic main_start_r; // Main cycle start
  logic core_start_r; // Core cycle start
  logic fault; // Converter forced off
  logic lp_active; // Qualified sleep request
  logic sleep; // Charger sleep state
  logic chg_valid; // Valid charger supply
  logic unit_tick; // Blink time unit done
  logic pg_on; // Supply good asserted
  pg_mode_t pg_mode; // Supply-good source
  logic wr_en; // Write takes effect

  // ****************************************
  // Functions
  // ****************************************
  // RL6 indicator mode decode
  function automatic pg_mode_t pg_mode_f(input logic [7:0] on_t, input logic [7:0] per);
    pg_mode_t m;
    m = PG_CHARGER;
    if (on_t == 8'h00 && per == 8'h00) m = PG_CHARGER;
    else if (on_t == 8'h00) m = PG_OFF;
    else if (on_t >= per) m = PG_ON;
    else m = PG_BLINK;
    return m;
  endfunction : pg_mode_f

  // Register read mux, unmapped reads zero
  function automatic logic [31:0] reg_read_f(input logic [4:0] adr);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (adr)
      `OFS_CHARGER_CONFIG: d[7:0] = chg_cfg_r;
      `OFS_INDICATOR_ON: d[7:0] = on_time_r;
      `OFS_INDICATOR_PER: d[7:0] = period_r;
      `OFS_CONV_CTRL_A: d[7:0] = ctrl_a_r;
      `OFS_CONV_CTRL_B: d[7:0] = ctrl_b_r;
      // RL23 power-good status
      `OFS_STATUS: d[15:0] = {core_vsel_r, main_vsel_r,
        core_drive_o.pfm, main_drive_o.pfm,
        core_enable_o & core_s.pgood, main_enable_i & ~fault & main_s.pgood,
        charge_suspend_o, sleep, 1'b0, supply_good_oe_o};
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : reg_read_f

  // ****************************************
  // Flag synchroniser
  // ****************************************
  // RL24 two flip-flop stages
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {charger_flags_i, main_flags_i, core_flags_i};
      sync_r <= meta_r;
    end
  end
  assign {chg_s, main_s, core_s} = sync_r;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // One wait cycle, then answer; idle waitrequest stays high, straight from a flop
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) avs_waitrequest_o <= 1'b1;
    else avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
  end
  assign ack = ~avs_waitrequest_o;
  assign wr_en = avs_write_i & ack;

  // Read data captured so they stand at the answer edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && !ack) avs_readdata_o <= reg_read_f(avs_address_i);
  end

  // Plain control registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      chg_cfg_r <= `REG_RESET_VAL;
      on_time_r <= `REG_RESET_VAL;
      period_r <= `REG_RESET_VAL;
      ctrl_a_r <= `REG_RESET_VAL;
      ctrl_b_r <= `REG_RESET_VAL;
    end else if (wr_en) begin
      case (avs_address_i)
        `OFS_CHARGER_CONFIG: chg_cfg_r <= avs_writedata_i[7:0];
        `OFS_INDICATOR_ON: on_time_r <= avs_writedata_i[7:0];
        `OFS_INDICATOR_PER: period_r <= avs_writedata_i[7:0];
        `OFS_CONV_CTRL_A: ctrl_a_r <= avs_writedata_i[7:0];
        `OFS_CONV_CTRL_B: ctrl_b_r <= avs_writedata_i[7:0];
        // Unmapped writes are dropped; status writes load only the target codes below
        default: ;
      endcase
    end
  end

  // ****************************************
  // Target voltages
  // ****************************************
  // RL8 RL9 straps sampled after release
  // RL10 later writes replace them
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strap_taken_r <= 1'b0;
      main_vsel_r <= `MAIN_VSEL_3V0;
      core_vsel_r <= `CORE_VSEL_1V5;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      main_vsel_r <= main_default_strap_i ? `MAIN_VSEL_3V3 : `MAIN_VSEL_3V0;
      core_vsel_r <= core_default_strap_i ? `CORE_VSEL_1V6 : `CORE_VSEL_1V5;
    end else if (wr_en && avs_address_i == `OFS_STATUS) begin
      // Target codes share the status word, upper byte
      main_vsel_r <= avs_writedata_i[11:8];
      core_vsel_r <= avs_writedata_i[15:12];
    end
  end

  // RL12 request needs enable bit
  assign lp_active = deep_sleep_request_i & ctrl_a_r[`CTRLA_LP_EN_BIT];
  assign fault = uvlo_i | battery_lid_open_i | overtemp_i;

  // RL11 lower or disable core
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      main_target_o <= `MAIN_VSEL_3V0;
      core_target_o <= `CORE_VSEL_1V5;
      core_enable_o <= 1'b0;
    end else begin
      main_target_o <= main_vsel_r;
      core_target_o <= lp_active ? {1'b0, ctrl_b_r[6:4]} : core_vsel_r;
      core_enable_o <= core_enable_i & ~fault & ~(lp_active & ctrl_b_r[`CTRLB_LP_OFF_BIT]);
    end
  end

  // RL22 discharge only when enabled
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      main_discharge_o <= 1'b0;
      core_discharge_o <= 1'b0;
    end else begin
      main_discharge_o <= fault & ctrl_a_r[`CTRLA_DIS_MAIN_BIT];
      core_discharge_o <= fault & ctrl_a_r[`CTRLA_DIS_CORE_BIT];
    end
  end

  // RL7 thermal charge suspend
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) charge_suspend_o <= 1'b0;
    else charge_suspend_o <= chg_s.tj_hot;
  end

  // ****************************************
  // Supply-good indication
  // ****************************************
  // RL3 sleep with no input
  assign sleep = ~chg_s.adapter_present & ~chg_s.usb_present;
  // RL1 RL4 valid source, overvoltage excluded
  assign chg_valid = (chg_s.adapter_valid & ~chg_s.adapter_ovp) | chg_s.usb_valid;
  assign pg_mode = pg_mode_f(on_time_r, period_r);

  // Blink time base, parameter shortens it in simulation
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || unit_tick) unit_cnt_r <= 20'h00000;
    else unit_cnt_r <= unit_cnt_r + 20'h00001;
  end
  assign unit_tick = (unit_cnt_r == 20'(BLINK_UNIT_CYC - 1));

  // RL25 blink counter restarts per period
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || pg_mode != PG_BLINK) blink_cnt_r <= 8'h00;
    else if (unit_tick) begin
      if (blink_cnt_r >= period_r - 8'h01) blink_cnt_r <= 8'h00;
      else blink_cnt_r <= blink_cnt_r + 8'h01;
    end
  end

  // RL6 source selection
  always_comb begin
    case (pg_mode)
      // RL2 charger source off in sleep
      PG_CHARGER: pg_on = chg_valid & ~sleep;
      PG_OFF: pg_on = 1'b0;
      PG_ON: pg_on = 1'b1;
      PG_BLINK: pg_on = blink_cnt_r < on_time_r;
      default: pg_on = 1'b0;
    endcase
  end

  // RL5 charger reset forces high-Z
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      supply_good_n_o <= 1'b0;
      supply_good_oe_o <= 1'b0;
    end else begin
      supply_good_n_o <= 1'b0;
      supply_good_oe_o <= pg_on & ~chg_cfg_r[`CHG_RESET_BIT];
    end
  end

  // ****************************************
  // Switching phase
  // ****************************************
  // RL14 fixed period counter
  // RL15 core start shifted from main
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase_r <= 4'h0;
      main_start_r <= 1'b0;
      core_start_r <= 1'b0;
    end else begin
      phase_r <= (phase_r == 4'(PWM_CYC - 1)) ? 4'h0 : phase_r + 4'h1;
      main_start_r <= (phase_r == 4'h0);
      core_start_r <= (phase_r == 4'(CORE_SHIFT));
    end
  end

  // RL13 forced PWM to both
  buck_switch_ctrl u_main (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .enable_i(main_enable_i & ~fault),
    .cycle_start_i(main_start_r),
    .force_pwm_i(ctrl_a_r[`CTRLA_FPWM_BIT]),
    .flags_i(main_s),
    .drive_o(main_drive_o)
  );

  buck_switch_ctrl u_core (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .enable_i(core_enable_o),
    .cycle_start_i(core_start_r),
    .force_pwm_i(ctrl_a_r[`CTRLA_FPWM_BIT]),
    .flags_i(core_s),
    .drive_o(core_drive_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  chk_pg_reset_hiz: assert property ( // RL5
    @(posedge clk_sys_i) disable iff (reset_i)
    chg_cfg_r[`CHG_RESET_BIT] |=> !supply_good_oe_o) else $error("supply good not high-Z");
  chk_pg_sleep_off: assert property ( // RL2
    @(posedge clk_sys_i) disable iff (reset_i)
    pg_mode == PG_CHARGER && sleep |=> !supply_good_oe_o) else $error("supply good on in sleep");
  chk_pg_valid_on: assert property ( // RL1
    @(posedge clk_sys_i) disable iff (reset_i)
    pg_mode == PG_CHARGER && chg_s.usb_valid && !sleep && !chg_cfg_r[`CHG_RESET_BIT]
    |=> supply_good_oe_o) else $error("supply good missing");
  chk_pg_ovp_block: assert property ( // RL4
    @(posedge clk_sys_i) disable iff (reset_i)
    pg_mode == PG_CHARGER && chg_s.adapter_ovp && !chg_s.usb_valid
    |=> !supply_good_oe_o) else $error("overvoltage adapter accepted");
  chk_tj_suspend: assert property ( // RL7
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(chg_s.tj_hot) |=> charge_suspend_o) else $error("charge not suspended");
  chk_lp_ignored: assert property ( // RL12
    @(posedge clk_sys_i) disable iff (reset_i)
    !ctrl_a_r[`CTRLA_LP_EN_BIT] && core_enable_i && !fault
    |=> core_enable_o && core_target_o == $past(core_vsel_r)) else $error("sleep request acted");
  chk_core_phase: assert property ( // RL15
    @(posedge clk_sys_i) disable iff (reset_i)
    main_start_r |-> ##6 core_start_r) else $error("core phase shift wrong");
  chk_discharge: assert property ( // RL22
    @(posedge clk_sys_i) disable iff (reset_i)
    !ctrl_a_r[`CTRLA_DIS_MAIN_BIT] |=> !main_discharge_o) else $error("discharge not enabled");
  chk_blink_wrap: assert property ( // RL25
    @(posedge clk_sys_i) disable iff (reset_i)
    pg_mode == PG_BLINK && unit_tick && blink_cnt_r == period_r - 8'h01 && $stable(period_r)
    |=> blink_cnt_r == 8'h00) else $error("blink period not restarted");
endmodule : buck_mode_pg_ctrl
`default_nettype wire

//--- pkg/buck_pg_defines.svh
/*
  Offsets, field positions, reset values and timing counts for the
  converter mode and supply-good control block.
  Assumes a 10 MHz system clock and a byte-addressed Avalon-MM slave.
*/
`ifndef BUCK_PG_DEFINES_SVH
`define BUCK_PG_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CHARGER_CONFIG 5'h00
`define OFS_INDICATOR_ON 5'h04
`define OFS_INDICATOR_PER 5'h08
`define OFS_CONV_CTRL_A 5'h0c
`define OFS_CONV_CTRL_B 5'h10
`define OFS_STATUS 5'h14

// ****************************************
// Field positions
// ****************************************
`define CHG_RESET_BIT 6
`define CTRLA_FPWM_BIT 7
`define CTRLA_LP_EN_BIT 6
`define CTRLA_DIS_MAIN_BIT 5
`define CTRLA_DIS_CORE_BIT 4
`define CTRLB_LP_OFF_BIT 7

// ****************************************
// Reset values and target codes
// ****************************************
`define REG_RESET_VAL 8'h00
`define MAIN_VSEL_3V0 4'h0
`define MAIN_VSEL_3V3 4'h3
`define CORE_VSEL_1V5 4'h0
`define CORE_VSEL_1V6 4'h1

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 10000000
`define PWM_HZ 1250000
`define PHASE_DEG 270
`define DEAD_NS 100
`define SS_STEP_US 100
`define BLINK_UNIT_US 10000
`define PWM_CYC (`CLK_HZ / `PWM_HZ)
`define CORE_SHIFT_CYC ((`PWM_CYC * `PHASE_DEG) / 360)
`define DEAD_CYC ((`DEAD_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SS_STEP_CYC (`SS_STEP_US * (`CLK_HZ / 1000000))
`define BLINK_UNIT_CYC (`BLINK_UNIT_US * (`CLK_HZ / 1000000))

`endif

//--- pkg/buck_pkg.sv
/*
  Types shared by the converter control files.
  Assumes nothing beyond a SystemVerilog elaborator.
*/
package buck_pkg;
  // Per-converter comparator flags
  typedef struct packed {
    logic vreg_trip;
    logic ilim_trip;
    logic skip;
    logic below_low;
    logic above_high;
    logic below_nom;
    logic dropout;
    logic pgood;
  } buck_flags_t;
  // Charger comparator flags
  typedef struct packed {
    logic adapter_valid;
    logic usb_valid;
    logic adapter_present;
    logic usb_present;
    logic adapter_ovp;
    logic tj_hot;
  } chg_flags_t;
  // Power stage drive of one converter
  typedef struct packed {
    logic hs;
    logic ls;
    logic pfm;
    logic [1:0] ilim_step;
  } buck_drive_t;
  // Switching cycle states
  typedef enum logic [1:0] {SW_IDLE, SW_HIGH, SW_DEAD, SW_LOW} sw_state_t;
  // Supply-good source
  typedef enum logic [1:0] {PG_CHARGER, PG_OFF, PG_ON, PG_BLINK} pg_mode_t;
endpackage : buck_pkg

//--- verilog/buck_switch_ctrl.sv
/*
  Switching cycle, power-save and soft-start control for one converter.
  Assumes flags already synchronised and a one-cycle start pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "buck_pg_defines.svh"
module buck_switch_ctrl #(
  parameter int DEAD_CYC = `DEAD_CYC,
  parameter int SS_STEP_CYC = `SS_STEP_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control
  input wire logic enable_i,
  input wire logic cycle_start_i,
  input wire logic force_pwm_i,
  input wire buck_pkg::buck_flags_t flags_i,
  // Power stage drive
  output var buck_pkg::buck_drive_t drive_o
);
  import buck_pkg::*;
  sw_state_t state_r, state_nxt; // Cycle state
  logic hs_r, ls_r, pfm_r, burst_r, half_r; // Drive and mode
  logic [1:0] step_r; // Current limit step
  logic [3:0] dead_cnt_r; // Dead time count
  logic [11:0] ss_cnt_r; // Step dwell count
  logic go; // Cycle may start

  if (DEAD_CYC < 1 || DEAD_CYC > 15 || SS_STEP_CYC < 1 || SS_STEP_CYC > 4096) begin : g_bad
    $error("buck_switch_ctrl: timing parameter out of range");
  end

  // RL18 half rate burst
  assign go = cycle_start_i & enable_i & (~pfm_r | (burst_r & half_r));

  // RL16 cycle sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SW_IDLE: if (go) state_nxt = SW_HIGH;
      SW_HIGH: begin
        // RL20 dropout keeps switch on
        if (!enable_i) state_nxt = SW_IDLE;
        else if (flags_i.ilim_trip || (flags_i.vreg_trip && !flags_i.dropout)) state_nxt = SW_DEAD;
      end
      SW_DEAD: begin
        if (!enable_i) state_nxt = SW_IDLE;
        else if (dead_cnt_r == 4'(DEAD_CYC - 1)) state_nxt = SW_LOW;
      end
      SW_LOW: begin
        // RL18 burst over, all idle
        if (!enable_i || (pfm_r && !burst_r)) state_nxt = SW_IDLE;
        else if (go) state_nxt = SW_HIGH;
      end
      default: state_nxt = SW_IDLE;
    endcase
  end

  // State and registered drive
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= SW_IDLE;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hs_r <= (state_nxt == SW_HIGH);
      ls_r <= (state_nxt == SW_LOW);
    end
  end

  // Dead time counter
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || state_r != SW_DEAD) dead_cnt_r <= 4'h0;
    else dead_cnt_r <= dead_cnt_r + 4'h1;
  end

  // RL17 RL19 power-save entry and exit
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !enable_i || force_pwm_i) pfm_r <= 1'b0;
    else if (pfm_r && burst_r && flags_i.below_nom) pfm_r <= 1'b0;
    else if (!pfm_r && flags_i.skip) pfm_r <= 1'b1;
  end

  // RL18 burst window and half rate
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !pfm_r) begin
      burst_r <= 1'b0;
      half_r <= 1'b1;
    end else begin
      if (flags_i.below_low) burst_r <= 1'b1;
      else if (flags_i.above_high) burst_r <= 1'b0;
      if (cycle_start_i) half_r <= ~half_r;
    end
  end

  // RL21 soft start in four steps
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !enable_i) begin
      step_r <= 2'd0;
      ss_cnt_r <= 12'h000;
    end else if (step_r != 2'd3) begin
      if (ss_cnt_r == 12'(SS_STEP_CYC - 1)) begin
        ss_cnt_r <= 12'h000;
        step_r <= step_r + 2'd1;
      end else ss_cnt_r <= ss_cnt_r + 12'h001;
    end
  end

  assign drive_o = '{hs: hs_r, ls: ls_r, pfm: pfm_r, ilim_step: step_r};

  // RL13 forced PWM
  chk_fpwm_no_pfm: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL13
    force_pwm_i |=> !drive_o.pfm) else $error("power-save under forced PWM");
  // RL19 exit on nominal threshold
  chk_pfm_exit: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL19
    pfm_r && burst_r && flags_i.below_nom |=> !pfm_r) else $error("power-save not left");
  // RL16 trip ends on-time
  chk_trip_off: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL16
    state_r == SW_HIGH && enable_i
    && (flags_i.ilim_trip || (flags_i.vreg_trip && !flags_i.dropout)) |=> !hs_r ##1 !hs_r)
    else $error("switch stayed on after trip");
endmodule : buck_switch_ctrl
`default_nettype wire

//--- test/analog_stage_model.sv
/*
  Behavioural analog power stage for one converter.
  Assumes drive comes from the control block on clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module analog_stage_model (
  // Clock and control from bench
  input wire logic clk_sys_i,
  input wire logic skip_i,
  input wire logic sag_i,
  // Drive in, comparator flags out
  input wire buck_pkg::buck_drive_t drive_i,
  output var buck_pkg::buck_flags_t flags_o
);
  import buck_pkg::*;
  int on_cnt; // High-side on-time
  // Inductor current ramps while high side conducts
  always_ff @(posedge clk_sys_i) begin
    on_cnt <= drive_i.hs ? on_cnt + 1 : 0;
  end
  always_comb begin
    flags_o = '0;
    flags_o.vreg_trip = (on_cnt >= 2);
    flags_o.skip = skip_i;
    flags_o.above_high = skip_i;
    // a load step sags past both thresholds
    flags_o.below_low = sag_i;
    flags_o.below_nom = sag_i;
    flags_o.pgood = 1'b1;
  end
endmodule : analog_stage_model
`default_nettype wire

//--- test/buck_mode_and_pg_control_tb_top.sv
/*
  Self-checking bench for buck_mode_pg_ctrl.
  Assumes the package, defines header and stage model.
*/
`timescale 1ns/1ps
`default_nettype none
module buck_mode_and_pg_control_tb_top;
  import buck_pkg::*;
  logic clk_sys_i, reset_i, rd, wr, wreq, pg_n, oe, cen, mdis, cdis, susp, ms, cs, slp, uv, skip;
  logic sag, men, ph, pk;
  logic [4:0] adr;
  logic [31:0] wd, rq, rdat, seed, q;
  logic [3:0] mt, ct;
  chg_flags_t cf;
  buck_flags_t mf, kf;
  buck_drive_t md, kd;
  int mismatches, cmp_count, n, k, on, per, cfg;
  buck_mode_pg_ctrl #(.BLINK_UNIT_CYC(4)) i_buck_mode_pg_ctrl (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_readdata_o(rq), .avs_waitrequest_o(wreq),
    .charger_flags_i(cf), .main_flags_i(mf), .core_flags_i(kf),
    .main_default_strap_i(ms), .core_default_strap_i(cs), .deep_sleep_request_i(slp),
    .main_enable_i(men), .core_enable_i(1'b1), .uvlo_i(uv), .battery_lid_open_i(1'b0),
    .overtemp_i(1'b0), .supply_good_n_o(pg_n), .supply_good_oe_o(oe), .main_target_o(mt),
    .core_target_o(ct), .core_enable_o(cen), .main_discharge_o(mdis),
    .core_discharge_o(cdis), .charge_suspend_o(susp), .main_drive_o(md), .core_drive_o(kd));
  analog_stage_model i_main_stage (.clk_sys_i(clk_sys_i), .skip_i(skip), .sag_i(sag),
    .drive_i(md), .flags_o(mf));
  analog_stage_model i_core_stage (.clk_sys_i(clk_sys_i), .skip_i(skip), .sag_i(sag),
    .drive_i(kd), .flags_o(kf));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Reference supply-good level from shadow registers and flags
  function automatic logic pg_exp();
    if (cfg[6]) return 1'b0;
    if (on == 0 && per == 0)
      return (cf.usb_valid | cf.adapter_valid & !cf.adapter_ovp) & (cf.adapter_present | cf.usb_present);
    return (on > 0 && on >= per);
  endfunction : pg_exp
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (e !== s) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a; wd <= d; rd <= !w; wr <= w;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    rdat = rq;
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task automatic give_verdict();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    give_verdict();
  end
  initial begin
    seed = 32'haa2aa09b; q = xs(); ms = q[0]; cs = q[1];
    reset_i = 1'b1; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; cf = '0; slp = 1'b0;
    uv = 1'b0; skip = 1'b0; on = 0; per = 0; cfg = 0; sag = 1'b0; men = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("main_target", ms ? 32'h3 : 32'h0, mt);
    chk("core_target", cs ? 32'h1 : 32'h0, ct);
    for (int i = 0; i < 5; i++) begin
      cf <= chg_flags_t'(i == 0 ? 6'h14 : i == 1 ? 6'h2a : i == 2 ? 6'h30 : i == 3 ? 6'h29 : 6'h28);
      repeat (5) @(posedge clk_sys_i);
      chk("supply_good", pg_exp(), oe);
      chk("suspend", cf.tj_hot, susp);
    end
    cfg = 32'h40; bus(1, 5'h00, cfg); repeat (2) @(posedge clk_sys_i);
    chk("pg_reset", pg_exp(), oe);
    chk("pg_drive_low", 0, pg_n);
    cfg = 0; bus(1, 5'h00, 0);
    per = 5; bus(1, 5'h08, per); repeat (2) @(posedge clk_sys_i);
    chk("pg_off", pg_exp(), oe);
    on = 7; bus(1, 5'h04, on); repeat (2) @(posedge clk_sys_i);
    chk("pg_on", pg_exp(), oe);
    bus(0, 5'h14, 0);
    chk("status_pg", pg_exp(), rdat[0]);
    chk("status_pgood", 2'b11, rdat[5:4]);
    bus(0, 5'h1c, 0);
    chk("unmapped", 0, rdat);
    on = 1; per = 2; bus(1, 5'h08, per); bus(1, 5'h04, on); n = 0;
    repeat (8) @(posedge clk_sys_i);
    repeat (24) begin @(posedge clk_sys_i); n += oe; end
    chk("blink", 24 * on / per, n);
    on = 0; per = 0; bus(1, 5'h04, 0); bus(1, 5'h08, 0);
    q = xs(); bus(1, 5'h14, {16'h0, q[15:8], 8'h0}); repeat (2) @(posedge clk_sys_i);
    chk("sw_main", q[11:8], mt);
    chk("sw_core", q[15:12], ct);
    slp <= 1'b1; bus(1, 5'h10, {25'h0, q[18:16], 4'h0}); repeat (3) @(posedge clk_sys_i);
    chk("lp_ignored", q[15:12], ct);
    bus(1, 5'h0c, 32'h40); repeat (3) @(posedge clk_sys_i);
    chk("lp_lower", {1'b0, q[18:16]}, ct);
    bus(1, 5'h10, 32'h80); repeat (3) @(posedge clk_sys_i);
    chk("lp_off", 0, cen);
    slp <= 1'b0; bus(1, 5'h0c, 32'h80); skip <= 1'b1;
    n = 0; k = 0; ph = md.hs; pk = kd.hs;
    repeat (40) begin
      @(posedge clk_sys_i);
      n += md.hs & !ph;
      k += kd.hs & !pk;
      ph = md.hs;
      pk = kd.hs;
    end
    chk("fpwm", 0, md.pfm);
    chk("pwm_main", 5, n);
    chk("pwm_core", 5, k);
    bus(1, 5'h0c, 0); repeat (40) @(posedge clk_sys_i);
    chk("pfm", 1, md.pfm);
    chk("pfm_core", 1, kd.pfm);
    skip <= 1'b0; sag <= 1'b1; repeat (8) @(posedge clk_sys_i);
    chk("pfm_exit", 0, md.pfm);
    sag <= 1'b0; men <= 1'b0; repeat (4) @(posedge clk_sys_i);
    chk("ss_clear", 0, md.ilim_step);
    men <= 1'b1; repeat (1500) @(posedge clk_sys_i);
    chk("ss_step", 1, md.ilim_step);
    repeat (1600) @(posedge clk_sys_i);
    chk("soft_start", 3, md.ilim_step);
    bus(1, 5'h0c, 32'h20); uv <= 1'b1; repeat (3) @(posedge clk_sys_i);
    chk("dis_main", 1, mdis);
    chk("dis_core", 0, cdis);
    bus(0, 5'h14, 0);
    chk("status_fault", 0, rdat[5:4]);
    uv <= 1'b0;
    give_verdict();
  end
endmodule : buck_mode_and_pg_control_tb_top
`default_nettype wire
